// [hw/touch_ctrl_config_regmap.sv]
// Register map of the touch controller: configuration, commands, status, alert
module touch_ctrl_config_regmap #(
  parameter int NUM_SENSORS = 16,
  parameter int RESET_SHARED_PIN = 15
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_por_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_busy,
  input wire logic [6:0] i_op_addr,
  output logic [7:0] o_op_data,
  output logic o_reg_bypass,
  input wire logic [NUM_SENSORS-1:0] i_short_gnd,
  input wire logic [NUM_SENSORS-1:0] i_short_vdd,
  input wire logic [NUM_SENSORS-1:0] i_short_sensor,
  input wire logic [NUM_SENSORS-1:0] i_short_shield,
  input wire logic [NUM_SENSORS-1:0] i_sensor_status,
  input wire logic [7:0] i_slider_pos,
  input wire logic i_refresh_tick,
  output logic o_host_alert_line_o,
  output logic o_host_alert_line_oe
);
  localparam int NS = NUM_SENSORS;

  function automatic logic [7:0] byte_of(input logic [15:0] v, input logic hi);
    byte_of = hi ? v[15:8] : v[7:0];
  endfunction : byte_of

  function automatic logic [15:0] widen(input logic [NS-1:0] v);
    logic [15:0] w;
    w = 16'h0000;
    w[NS-1:0] = v;
    widen = w;
  endfunction : widen

  touch_cfg_pkg::map_state_e state_ff, nxt_state;
  logic [7:0] idx_ff, nxt_idx;
  logic [7:0] result_ff;
  logic slot_ff;
  logic use_nvm_ff;
  logic [NS-1:0] gnd_s1_ff, gnd_s2_ff, vdd_s1_ff, vdd_s2_ff;
  logic [NS-1:0] sns_s1_ff, sns_s2_ff, shd_s1_ff, shd_s2_ff;
  logic [NS-1:0] diag_gnd_ff, diag_vdd_ff, diag_sns_ff, diag_shd_ff;
  logic [NS-1:0] prev_sensor_ff;
  logic [7:0] prev_slider_ff;
  logic alert_pend_ff;
  logic [15:0] alert_cnt_ff;
  logic [7:0] rd_data_ff;
  logic rd_valid_ff;
  logic [7:0] op_data_ff;
  logic [7:0] shadow [0:touch_cfg_pkg::CFG_DEPTH-1];
  logic [7:0] active [0:touch_cfg_pkg::CFG_DEPTH-1];

  // Address decode
  wire in_cfg = i_addr <= touch_cfg_pkg::CFG_LAST;
  wire in_stat = (i_addr >= touch_cfg_pkg::STAT_FIRST) && (i_addr <= touch_cfg_pkg::STAT_LAST);
  wire is_idle = state_ff == touch_cfg_pkg::ST_IDLE;
  wire cfg_wr = i_wr_en && in_cfg && is_idle;
  wire cmd_wr = i_wr_en && (i_addr == touch_cfg_pkg::CMD_CTRL_ADDR) && is_idle;
  wire save_go = cmd_wr && (i_wdata == touch_cfg_pkg::CMD_SAVE);
  wire bad_cmd = cmd_wr && (i_wdata != touch_cfg_pkg::CMD_SAVE)
                 && (i_wdata != touch_cfg_pkg::CMD_NONE);

  // NVM wiring
  logic [7:0] nvm_rd_data;
  logic [1:0] nvm_valid;
  logic nvm_newest;
  wire any_valid = |nvm_valid;
  wire pick_slot = nvm_valid[nvm_newest] ? nvm_newest : ~nvm_newest;
  wire save_slot = any_valid ? ~pick_slot : 1'b0;
  // Invalidate the save target, never the newest valid slot
  wire nvm_wr_slot = save_go ? save_slot : slot_ff;
  // First boot read comes before slot_ff has taken the picked slot
  wire boot_first = (state_ff == touch_cfg_pkg::ST_BOOT) && (idx_ff == 8'h00);
  wire nvm_rd_slot = boot_first ? pick_slot : slot_ff;
  wire [6:0] idx7 = idx_ff[6:0];
  wire [6:0] idx_prev = 7'(idx_ff - 8'h01);
  wire boot_wr = (state_ff == touch_cfg_pkg::ST_BOOT) && (idx_ff != 8'h00);
  wire save_wr = (state_ff == touch_cfg_pkg::ST_SAVE) && (idx_ff < touch_cfg_pkg::CFG_DEPTH_B);
  wire save_done = (state_ff == touch_cfg_pkg::ST_SAVE) && (idx_ff == touch_cfg_pkg::CFG_DEPTH_B);
  wire boot_done = (state_ff == touch_cfg_pkg::ST_BOOT) && (idx_ff == touch_cfg_pkg::CFG_DEPTH_B);
  wire [7:0] boot_byte = use_nvm_ff ? nvm_rd_data : touch_cfg_pkg::FACTORY_BYTE;

  nvm_dual_slot #(
    .DEPTH(touch_cfg_pkg::CFG_DEPTH),
    .AW(7)
  ) u_nvm (
    .i_ref_clk(i_ref_clk),
    .i_por_n(i_por_n),
    .i_wr_en(save_wr),
    .i_wr_slot(nvm_wr_slot),
    .i_wr_addr(idx7),
    .i_wr_data(shadow[idx7]),
    .i_invalidate(save_go),
    .i_commit(save_done),
    .i_rd_slot(nvm_rd_slot),
    .i_rd_addr(idx7),
    .o_rd_data(nvm_rd_data),
    .o_valid(nvm_valid),
    .o_newest(nvm_newest)
  );

  // Sequencer: boot copy after every reset, save copy on command
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    case (state_ff)
      touch_cfg_pkg::ST_BOOT: begin
        nxt_idx = 8'(idx_ff + 8'h01);
        if (boot_done) begin
          nxt_state = touch_cfg_pkg::ST_IDLE;
          nxt_idx = 8'h00;
        end
      end
      touch_cfg_pkg::ST_IDLE: begin
        if (save_go) begin
          nxt_state = touch_cfg_pkg::ST_SAVE;
          nxt_idx = 8'h00;
        end
      end
      touch_cfg_pkg::ST_SAVE: begin
        nxt_idx = 8'(idx_ff + 8'h01);
        if (save_done) begin
          nxt_state = touch_cfg_pkg::ST_IDLE;
          nxt_idx = 8'h00;
        end
      end
      default: begin
        nxt_state = touch_cfg_pkg::ST_BOOT;
        nxt_idx = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= touch_cfg_pkg::ST_BOOT;
      idx_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
    end
  end

  // Source chosen at the first boot cycle and held for the whole copy
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      slot_ff <= 1'b0;
      use_nvm_ff <= 1'b0;
    end else if ((state_ff == touch_cfg_pkg::ST_BOOT) && (idx_ff == 8'h00)) begin
      slot_ff <= pick_slot;
      use_nvm_ff <= any_valid;
    end else if (save_go) begin
      slot_ff <= save_slot;
    end
  end

  // Active copy changes only at boot, so host edits wait for save and reset
  always_ff @(posedge i_ref_clk) begin
    if (boot_wr) begin
      shadow[idx_prev] <= boot_byte;
      active[idx_prev] <= boot_byte;
    end else if (cfg_wr) begin
      shadow[i_addr[6:0]] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      result_ff <= touch_cfg_pkg::RES_RESET;
    end else if (bad_cmd) begin
      result_ff <= touch_cfg_pkg::RES_BAD_CMD;
    end else if (save_done) begin
      result_ff <= touch_cfg_pkg::RES_OK;
    end
  end

  // Fault inputs come from the analog side, so synchronise them
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gnd_s1_ff <= '0;
      gnd_s2_ff <= '0;
      vdd_s1_ff <= '0;
      vdd_s2_ff <= '0;
      sns_s1_ff <= '0;
      sns_s2_ff <= '0;
      shd_s1_ff <= '0;
      shd_s2_ff <= '0;
    end else begin
      gnd_s1_ff <= i_short_gnd;
      gnd_s2_ff <= gnd_s1_ff;
      vdd_s1_ff <= i_short_vdd;
      vdd_s2_ff <= vdd_s1_ff;
      sns_s1_ff <= i_short_sensor;
      sns_s2_ff <= sns_s1_ff;
      shd_s1_ff <= i_short_shield;
      shd_s2_ff <= shd_s1_ff;
    end
  end

  wire [NS-1:0] gnd_mask = ~(NS'(1) << RESET_SHARED_PIN);

  // Diagnostics captured once per reset, at the end of boot
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      diag_gnd_ff <= '0;
      diag_vdd_ff <= '0;
      diag_sns_ff <= '0;
      diag_shd_ff <= '0;
    end else if (boot_done) begin
      diag_gnd_ff <= gnd_s2_ff & gnd_mask;
      diag_vdd_ff <= vdd_s2_ff;
      diag_sns_ff <= sns_s2_ff;
      diag_shd_ff <= shd_s2_ff;
    end
  end

  // Status read mux; writes never reach these sources
  wire [7:0] ro = i_addr - touch_cfg_pkg::STAT_FIRST;
  wire hi_b = i_addr[0];
  wire [7:0] stat_byte =
    (i_addr == touch_cfg_pkg::STAT_CMD_BUSY) ? {7'h00, ~is_idle} :
    (i_addr == touch_cfg_pkg::STAT_CMD_RESULT) ? result_ff :
    (i_addr[7:1] == touch_cfg_pkg::STAT_SHORT_GND_LO[7:1]) ? byte_of(widen(diag_gnd_ff), hi_b) :
    (i_addr[7:1] == touch_cfg_pkg::STAT_SHORT_VDD_LO[7:1]) ? byte_of(widen(diag_vdd_ff), hi_b) :
    (i_addr[7:1] == touch_cfg_pkg::STAT_SHORT_SNS_LO[7:1]) ? byte_of(widen(diag_sns_ff), hi_b) :
    (i_addr[7:1] == touch_cfg_pkg::STAT_SHORT_SHLD_LO[7:1]) ? byte_of(widen(diag_shd_ff), hi_b) :
    (i_addr[7:1] == touch_cfg_pkg::STAT_SENSOR_LO[7:1]) ? byte_of(widen(prev_sensor_ff), hi_b) :
    (i_addr == touch_cfg_pkg::STAT_SLIDER) ? prev_slider_ff : 8'h00;
  wire [7:0] rd_mux = in_cfg ? shadow[i_addr[6:0]] : (in_stat && (ro < 8'h74)) ? stat_byte : 8'h00;

  // Status writes fall through every decode above and are dropped
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= i_rd_en;
      if (i_rd_en) begin
        rd_data_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    op_data_ff <= active[i_op_addr];
  end

  // Alert: change arms a pending flag; pulses start only on refresh ticks
  wire changed = (i_sensor_status != prev_sensor_ff) || (i_slider_pos != prev_slider_ff);
  wire alert_on = alert_cnt_ff != 16'h0000;
  wire alert_start = alert_pend_ff && i_refresh_tick && !alert_on && is_idle;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_sensor_ff <= '0;
      prev_slider_ff <= 8'h00;
      alert_pend_ff <= 1'b0;
      alert_cnt_ff <= 16'h0000;
    end else begin
      prev_sensor_ff <= i_sensor_status;
      prev_slider_ff <= i_slider_pos;
      // New change in the start cycle keeps the flag set
      if (changed) begin
        alert_pend_ff <= 1'b1;
      end else if (alert_start) begin
        alert_pend_ff <= 1'b0;
      end
      if (alert_start) begin
        alert_cnt_ff <= 16'(touch_cfg_pkg::ALERT_PULSE_CYC);
      end else if (alert_on) begin
        alert_cnt_ff <= 16'(alert_cnt_ff - 16'h0001);
      end
    end
  end

  assign o_host_alert_line_o = 1'b0;
  assign o_host_alert_line_oe = alert_on;
  assign o_rd_data = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_busy = !is_idle;
  assign o_op_data = op_data_ff;
  assign o_reg_bypass = active[touch_cfg_pkg::SETUP3_ADDR[6:0]][touch_cfg_pkg::SETUP3_BYPASS_BIT];
endmodule : touch_ctrl_config_regmap

// [inc/touch_cfg_pkg.sv]
// Address map, codes and timing of the touch controller register map
package touch_cfg_pkg;
  localparam logic [7:0] CFG_FIRST = 8'h00;
  localparam logic [7:0] CFG_LAST = 8'h7E;
  localparam logic [7:0] CMD_FIRST = 8'h80;
  localparam logic [7:0] CMD_LAST = 8'h87;
  localparam logic [7:0] STAT_FIRST = 8'h88;
  localparam logic [7:0] STAT_LAST = 8'hFB;
  localparam int CFG_DEPTH = 127;
  localparam logic [7:0] CFG_DEPTH_B = 8'h7F;

  localparam logic [7:0] CMD_CTRL_ADDR = 8'h86;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_SAVE = 8'h02;

  localparam logic [7:0] STAT_CMD_BUSY = 8'h88;
  localparam logic [7:0] STAT_CMD_RESULT = 8'h89;
  localparam logic [7:0] STAT_SHORT_GND_LO = 8'h8A;
  localparam logic [7:0] STAT_SHORT_VDD_LO = 8'h8C;
  localparam logic [7:0] STAT_SHORT_SNS_LO = 8'h8E;
  localparam logic [7:0] STAT_SHORT_SHLD_LO = 8'h90;
  localparam logic [7:0] STAT_SENSOR_LO = 8'h92;
  localparam logic [7:0] STAT_SLIDER = 8'h94;

  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_BAD_CMD = 8'h01;
  localparam logic [7:0] RES_RESET = 8'h00;

  localparam logic [7:0] SETUP3_ADDR = 8'h4F;
  localparam int SETUP3_BYPASS_BIT = 3;
  localparam logic [7:0] FACTORY_BYTE = 8'h00;

  localparam int CLK_PERIOD_NS = 50;
  localparam int CMD_LATENCY_LIMIT_US = 15;
  localparam int CMD_LATENCY_CYC = (CMD_LATENCY_LIMIT_US * 1000) / CLK_PERIOD_NS;
  localparam int ALERT_PULSE_US = 50;
  localparam int ALERT_PULSE_CYC = (ALERT_PULSE_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_SAVE = 3'b100
  } map_state_e;
endpackage : touch_cfg_pkg

// [hw/nvm_dual_slot.sv]
// Two-slot non-volatile configuration store with valid flags and newest pointer
module nvm_dual_slot #(
  parameter int DEPTH = 127,
  parameter int AW = 7
) (
  input wire logic i_ref_clk,
  input wire logic i_por_n,
  input wire logic i_wr_en,
  input wire logic i_wr_slot,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_invalidate,
  input wire logic i_commit,
  input wire logic i_rd_slot,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic [1:0] o_valid,
  output logic o_newest
);
  logic [7:0] mem [0:2*DEPTH-1];
  logic [1:0] valid_ff;
  logic newest_ff;
  logic [7:0] rd_data_ff;

  // Contents survive the pin reset; only power-on clears the flags
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem[i_wr_slot ? (DEPTH + int'(i_wr_addr)) : int'(i_wr_addr)] <= i_wr_data;
    end
    rd_data_ff <= mem[i_rd_slot ? (DEPTH + int'(i_rd_addr)) : int'(i_rd_addr)];
  end

  // Slot is marked invalid before its bytes change, valid only after the last
  always_ff @(posedge i_ref_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      valid_ff <= 2'h0;
      newest_ff <= 1'b0;
    end else if (i_invalidate) begin
      valid_ff[i_wr_slot] <= 1'b0;
    end else if (i_commit) begin
      valid_ff[i_wr_slot] <= 1'b1;
      newest_ff <= i_wr_slot;
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_valid = valid_ff;
  assign o_newest = newest_ff;
endmodule : nvm_dual_slot

// [dv/touch_host_model.sv]
// Host side model: register port master and pulled-up alert line
module touch_host_model (
  input wire logic i_ref_clk,
  input wire logic i_alert_oe,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_alert_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open drain with pull-up: high whenever the device lets go
  assign o_alert_n = i_alert_oe ? 1'b0 : 1'b1;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // One byte write, held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_addr = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_ref_clk);
    o_wr_en = 1'b0;
    // Idle bus shows no stale value
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
  // Status fetch, also used in answer to an alert
  task automatic rd(input logic [7:0] a);
    @(negedge i_ref_clk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_ref_clk);
    o_rd_en = 1'b0;
    o_addr = ~a;
  endtask : rd
endmodule : touch_host_model

// [dv/touch_ctrl_config_regmap_assertions.sv]
// Port-level checker for the touch controller register map
module touch_regmap_checker (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic o_rd_valid,
  input wire logic o_busy,
  input wire logic [6:0] i_op_addr,
  input wire logic [7:0] o_op_data,
  input wire logic o_reg_bypass,
  input wire logic i_refresh_tick,
  input wire logic o_host_alert_line_o,
  input wire logic o_host_alert_line_oe
);
  logic [10:0] width_ff;
  wire save_cmd = i_wr_en && !o_busy && (i_addr == touch_cfg_pkg::CMD_CTRL_ADDR)
    && (i_wdata == touch_cfg_pkg::CMD_SAVE);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  // Counts low time of the alert line
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) width_ff <= 11'h000;
    else if (o_host_alert_line_oe) width_ff <= width_ff + 11'h001;
    else width_ff <= 11'h000;
  end
  a_read_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  a_read_spurious: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("read valid without request");
  a_save_latency: assert property (save_cmd |=> o_busy[*8] ##[110:130] !o_busy)
    else $error("save timing wrong");
  a_alert_width: assert property ($fell(o_host_alert_line_oe) |-> width_ff == 11'h3E8)
    else $error("alert pulse width wrong");
  a_alert_cap: assert property (width_ff <= 11'h3E8)
    else $error("alert pulse too long");
  a_alert_tick: assert property ($rose(o_host_alert_line_oe) |-> $past(i_refresh_tick))
    else $error("alert not on refresh tick");
  a_alert_level: assert property (o_host_alert_line_o == 1'b0)
    else $error("alert drives high");
  a_bypass_hold: assert property (!o_busy && !$past(o_busy) |-> $stable(o_reg_bypass))
    else $error("bypass changed outside boot");
  a_active_hold: assert property (!o_busy && !$past(o_busy) && $stable(i_op_addr)
    |=> $stable(o_op_data))
    else $error("active config changed outside boot");
  c_alert: cover property ($rose(o_host_alert_line_oe));
  c_busy_end: cover property ($fell(o_busy));
  c_read: cover property (o_rd_valid);
endmodule : touch_regmap_checker
bind touch_ctrl_config_regmap touch_regmap_checker chk_i (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rd_valid(o_rd_valid), .o_busy(o_busy),
  .i_op_addr(i_op_addr), .o_op_data(o_op_data), .o_reg_bypass(o_reg_bypass),
  .i_refresh_tick(i_refresh_tick), .o_host_alert_line_o(o_host_alert_line_o),
  .o_host_alert_line_oe(o_host_alert_line_oe)
);

// [dv/touch_ctrl_config_regmap_bench.sv]
// Self-checking bench for the touch controller register map
module touch_ctrl_config_regmap_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_por_n = 1'b0;
  logic [6:0] i_op_addr = 7'h00;
  logic [15:0] sh_gnd = 16'h0000;
  logic [15:0] sh_vdd = 16'h0000;
  logic [15:0] sh_sns = 16'h0000;
  logic [15:0] sh_shd = 16'h0000;
  logic [15:0] sens = 16'h0000;
  logic [7:0] slider = 8'h00;
  logic tick = 1'b0;
  wire wr_en, rd_en, rd_valid, busy, bypass, al_o, al_oe, al_n;
  wire [7:0] addr, wdata, rd_data, op_data;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  always #25 i_ref_clk = ~i_ref_clk;
  touch_ctrl_config_regmap uut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_por_n(i_por_n), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_busy(busy), .i_op_addr(i_op_addr), .o_op_data(op_data),
    .o_reg_bypass(bypass), .i_short_gnd(sh_gnd), .i_short_vdd(sh_vdd),
    .i_short_sensor(sh_sns), .i_short_shield(sh_shd), .i_sensor_status(sens),
    .i_slider_pos(slider), .i_refresh_tick(tick), .o_host_alert_line_o(al_o),
    .o_host_alert_line_oe(al_oe));
  touch_host_model host (.i_ref_clk(i_ref_clk), .i_alert_oe(al_oe), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata), .o_alert_n(al_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] e, input string what);
    num_checks++;
    if (got !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd
  task automatic op(input logic [6:0] a, input logic [7:0] e);
    @(negedge i_ref_clk);
    i_op_addr = a;
    @(negedge i_ref_clk);
    chk(op_data, e, "active config");
  endtask : op
  task automatic wait_idle();
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge i_ref_clk);
  endtask : wait_idle
  task automatic reset_dut(input logic por);
    @(negedge i_ref_clk);
    i_resetn = 1'b0;
    i_por_n = ~por;
    repeat (20) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    i_por_n = 1'b1;
    wait_idle();
  endtask : reset_dut
  task automatic wait_alert(input logic lvl);
    for (n = 0; n < 1100 && al_n !== lvl; n++) @(negedge i_ref_clk);
    chk({7'h00, al_n}, {7'h00, lvl}, "alert line");
  endtask : wait_alert
  task automatic pulse_tick();
    @(negedge i_ref_clk);
    tick = 1'b1;
    @(negedge i_ref_clk);
    tick = 1'b0;
  endtask : pulse_tick
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // Reads are matched in issue order against the noted expectations
  always @(negedge i_ref_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0) chk(rd_data, exp_q.pop_front(), "read data");
      else chk(8'h00, 8'hFF, "unrequested read");
    end
  end
  initial begin
    #2000000;
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(22));
    reset_dut(1'b1);
    chk({7'h00, bypass}, 8'h00, "bypass");
    op(7'h4F, touch_cfg_pkg::FACTORY_BYTE);
    r = 8'($urandom());
    host.wr(8'h10, r);
    host.wr(touch_cfg_pkg::SETUP3_ADDR, 8'h08);
    rd(8'h10, r);
    op(7'h10, touch_cfg_pkg::FACTORY_BYTE);
    // Bad code first, so a finished save visibly clears the result
    host.wr(touch_cfg_pkg::CMD_CTRL_ADDR, 8'h55);
    rd(touch_cfg_pkg::STAT_CMD_RESULT, touch_cfg_pkg::RES_BAD_CMD);
    host.wr(touch_cfg_pkg::CMD_CTRL_ADDR, touch_cfg_pkg::CMD_SAVE);
    @(negedge i_ref_clk);
    wait_idle();
    chk({7'h00, n < touch_cfg_pkg::CMD_LATENCY_CYC}, 8'h01, "save latency");
    rd(touch_cfg_pkg::STAT_CMD_RESULT, touch_cfg_pkg::RES_OK);
    rd(touch_cfg_pkg::STAT_CMD_BUSY, 8'h00);
    chk({7'h00, bypass}, 8'h00, "bypass before reset");
    sh_gnd = 16'($urandom()) | 16'h8000;
    sh_vdd = 16'($urandom());
    sh_sns = 16'($urandom());
    sh_shd = 16'($urandom());
    slider = 8'($urandom());
    reset_dut(1'b0);
    chk({7'h00, bypass}, 8'h01, "bypass after reset");
    op(7'h10, r);
    rd(8'h8A, sh_gnd[7:0]);
    rd(8'h8B, {1'b0, sh_gnd[14:8]});
    rd(8'h8C, sh_vdd[7:0]);
    rd(8'h8F, sh_sns[15:8]);
    rd(8'h91, sh_shd[15:8]);
    host.wr(touch_cfg_pkg::STAT_SLIDER, ~slider);
    rd(touch_cfg_pkg::STAT_SLIDER, slider);
    // Reset lands mid-save, so the slot written earlier must win
    host.wr(touch_cfg_pkg::SETUP3_ADDR, 8'h00);
    host.wr(touch_cfg_pkg::CMD_CTRL_ADDR, touch_cfg_pkg::CMD_SAVE);
    repeat (20) @(negedge i_ref_clk);
    reset_dut(1'b0);
    chk({7'h00, bypass}, 8'h01, "bypass after broken save");
    // A full save now lands in the other slot; byte 0 shows which slot booted
    r = 8'($urandom()) | 8'h01;
    host.wr(8'h00, r);
    host.wr(touch_cfg_pkg::SETUP3_ADDR, 8'h00);
    host.wr(touch_cfg_pkg::CMD_CTRL_ADDR, touch_cfg_pkg::CMD_SAVE);
    @(negedge i_ref_clk);
    wait_idle();
    reset_dut(1'b0);
    chk({7'h00, bypass}, 8'h00, "bypass from newest slot");
    op(7'h00, r);
    sens = 16'($urandom()) | 16'h0001;
    repeat (3) @(negedge i_ref_clk);
    pulse_tick();
    wait_alert(1'b0);
    rd(touch_cfg_pkg::STAT_SENSOR_LO, sens[7:0]);
    sens = ~sens;
    pulse_tick();
    wait_alert(1'b1);
    pulse_tick();
    wait_alert(1'b0);
    rd(8'h93, sens[15:8]);
    repeat (4) @(negedge i_ref_clk);
    chk({7'h00, exp_q.size() == 0}, 8'h01, "reads outstanding");
    final_report();
  end
endmodule : touch_ctrl_config_regmap_bench
